// *** logic/slfc_pkg.sv ***
// Function
// RL1 - Latch data, blank, waveform, contrast at frame
// RL2 - Enable starts; clearing stops at once
// RL3 - Disabled pins return to port function
// RL4 - Waveform select applies from next frame
// RL5 - Frame flag set with each data latch
// RL6 - Interrupt needs flag, enable, global enable
// RL7 - Flag clears on vector or write one
// RL8 - Low-power waveform latches every second frame
// RL9 - Blanking after frame grounds all pins
// RL10 - Clock select: system or asynchronous source
// RL11 - Bias half or third; static duty static
// RL12 - Duty select picks one to four commons
// RL13 - Port mask picks active segment pin count
// RL14 - Reserved bits ignore writes, read zero
// RL15 - Software programs setup before enabling
// RL16 - Software disables before reinitialising
// RL17 - Software updates just after frame latch
// RL18 - Software blanks, waits a frame, then disables
// RL19 - Software avoids read-modify-write of flag
// RL20 - Commons addressed in order from zero
// RL21 - Set bit drives segment opposite to common
// RL22 - Prescaler divides 16 to 4096, then 1-8
// RL23 - Unblanking resumes output at next frame
package slfc_pkg;
    // Register byte addresses on the APB slave
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONFIG      = 8'h04;
    localparam logic [7:0] OFS_FRAME_RATE  = 8'h08;
    localparam logic [7:0] OFS_CONTRAST    = 8'h0C;
    localparam logic [7:0] OFS_DMEM_BASE   = 8'h10;
    localparam int         APB_AW          = 8;
    // Control and status register fields
    localparam int BIT_ENABLE  = 7;
    localparam int BIT_LPWAVE  = 6;
    localparam int BIT_IRQFLAG = 4;
    localparam int BIT_IRQEN   = 3;
    localparam int BIT_BLANK   = 0;
    // Configuration register fields
    localparam int BIT_CLKSEL  = 7;
    localparam int BIT_HALFB   = 6;
    localparam int POS_DUTY    = 4;
    localparam int POS_PMASK   = 0;
    // Frame rate register fields
    localparam int POS_PSSEL   = 4;
    localparam int POS_CLKDIV  = 0;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // Last prescaled tick of a frame, counted from zero
    localparam logic [2:0] K_NORMAL = 3'h7;
    localparam logic [2:0] K_THIRD  = 3'h5;
    localparam int         PS_WIDTH = 12;

    // Duty selection
    typedef enum logic [1:0] {
        SLFC_DUTY_STATIC,
        SLFC_DUTY_HALF,
        SLFC_DUTY_THIRD,
        SLFC_DUTY_QUARTER
    } slfc_duty_e;

    // Control register fields kept by software
    typedef struct packed {
        logic enable;
        logic lp_wave;
        logic irq_en;
        logic blank;
    } slfc_ctrl_s;

    // Configuration register fields
    typedef struct packed {
        logic       clk_sel;
        logic       half_bias;
        slfc_duty_e duty;
        logic [2:0] port_mask;
    } slfc_cfg_s;
endpackage : slfc_pkg

// *** logic/slfc_frame_ctrl.sv ***
`timescale 1ns/1ps
module slfc_frame_ctrl
    import slfc_pkg::*;
#(
    parameter int NUM_SEG = 25,
    parameter int NUM_COM = 4
)(
    input  wire logic                clk_sys,        // System clock, 125 MHz
    input  wire logic                reset,          // Async reset, active high
    input  wire logic                psel,           // APB select
    input  wire logic                penable,        // APB enable
    input  wire logic                pwrite,         // APB direction
    input  wire logic [APB_AW-1:0]   paddr,          // APB byte address
    input  wire logic [31:0]         pwdata,         // APB write data
    output logic                     pready,         // APB ready
    output logic [31:0]              prdata,         // APB read data
    output logic                     pslverr,        // APB error, unmapped
    input  wire logic                timer_osc_input, // Timer oscillator level
    input  wire logic                ext_clk_input,  // External clock level
    input  wire logic                ext_clock_select, // Pick external clock
    input  wire logic                global_irq_en,  // CPU global enable
    input  wire logic                irq_ack,        // Vector taken, pulse
    output logic                     frame_irq,      // Interrupt request
    output logic [NUM_SEG-1:0]       seg_out,        // Segment waveform level
    output logic [NUM_SEG-1:0]       seg_lcd_sel,    // Segment pin owned
    output logic [NUM_COM-1:0]       com_out,        // Common waveform level
    output logic [NUM_COM-1:0]       com_lcd_sel,    // Common pin owned
    output logic                     pins_grounded,  // Blanking in force
    output logic                     bias_half,      // Half bias selected
    output logic                     bias_static,    // Static bias in use
    output logic                     lp_wave_out,    // Low-power waveform
    output logic [3:0]               contrast_out    // Latched contrast
);
    // Refuse sizes the pin decode cannot serve
    if (NUM_SEG != 25 || NUM_COM != 4)
        $error("slfc_frame_ctrl supports 25 segments and 4 commons only");

    slfc_ctrl_s          ctrl_q;        // Control bits
    logic                flag_q;        // Frame interrupt flag
    slfc_cfg_s           cfg_q;         // Configuration
    logic [2:0]          pssel_q;       // Prescaler tap
    logic [2:0]          clkdiv_q;      // Extra divider
    logic [3:0]          contrast_q;    // Contrast setting
    logic [NUM_SEG-1:0]  dmem_q [NUM_COM]; // Display memory
    logic [NUM_SEG-1:0]  dlat_q [NUM_COM]; // Working latches
    logic                blank_lat_q;   // Latched blanking
    logic                lp_lat_q;      // Latched waveform
    logic [3:0]          cc_lat_q;      // Latched contrast
    logic                async_d1_q;    // Async source previous level
    logic [PS_WIDTH-1:0] ps_q;          // Ripple prescaler
    logic [2:0]          div_q;         // Divider count
    logic [2:0]          phase_q;       // Tick within frame
    logic                first_q;       // First enabled cycle opens frame one
    logic                parity_q;      // Frame parity
    logic                pol_q;         // Waveform polarity
    logic [31:0]         rdata_q;       // Read data
    logic                lcd_tick;      // Controller clock tick
    logic                ps_tick;       // Prescaled tick
    logic [PS_WIDTH-1:0] tap_mask;      // Prescaler tap mask
    logic [2:0]          k_last;        // Last phase of a frame
    logic                frame_start;   // A frame begins
    logic                latch_ev;      // Data latch event
    logic [1:0]          com_idx;       // Addressed common
    logic                wr_ev;         // Write takes effect
    logic                mapped;        // Address decodes
    logic [4:0]          seg_cnt;       // Segment pins in use

    // Bus decode; always ready, so every access phase completes
    assign pready  = 1'b1;
    assign wr_ev   = psel && penable && pwrite;
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= OFS_DMEM_BASE + 8'h0C);
    assign pslverr = psel && penable && !mapped;
    assign prdata  = rdata_q;

    // Read data registered in the setup cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            rdata_q <= 32'h0000_0000;
            // Reserved bits stay zero in every case below
            unique case (paddr)     // see RL14
                OFS_CTRL_STATUS:
                begin
                    rdata_q[BIT_ENABLE]  <= ctrl_q.enable;
                    rdata_q[BIT_LPWAVE]  <= ctrl_q.lp_wave;
                    rdata_q[BIT_IRQFLAG] <= flag_q;
                    rdata_q[BIT_IRQEN]   <= ctrl_q.irq_en;
                    rdata_q[BIT_BLANK]   <= ctrl_q.blank;
                end
                OFS_CONFIG:
                    rdata_q[7:0] <= {cfg_q.clk_sel, cfg_q.half_bias, cfg_q.duty, 1'b0,
                                     cfg_q.port_mask};
                OFS_FRAME_RATE:
                    rdata_q[7:0] <= {1'b0, pssel_q, 1'b0, clkdiv_q};
                OFS_CONTRAST:
                    rdata_q[3:0] <= contrast_q;
                OFS_DMEM_BASE:        rdata_q[NUM_SEG-1:0] <= dmem_q[0];
                OFS_DMEM_BASE + 8'h04: rdata_q[NUM_SEG-1:0] <= dmem_q[1];
                OFS_DMEM_BASE + 8'h08: rdata_q[NUM_SEG-1:0] <= dmem_q[2];
                OFS_DMEM_BASE + 8'h0C: rdata_q[NUM_SEG-1:0] <= dmem_q[3];
                default:              rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Software-written registers; reserved positions are simply not stored
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q     <= slfc_ctrl_s'(4'h0);
            cfg_q      <= slfc_cfg_s'(RST_REG[6:0]);
            pssel_q    <= 3'h0;
            clkdiv_q   <= 3'h0;
            contrast_q <= 4'h0;
            for (int i = 0; i < NUM_COM; i++)
                dmem_q[i] <= '0;
        end
        else if (wr_ev)
        begin
            if (paddr == OFS_CTRL_STATUS)
            begin
                ctrl_q.enable  <= pwdata[BIT_ENABLE];    // see RL2
                ctrl_q.lp_wave <= pwdata[BIT_LPWAVE];
                ctrl_q.irq_en  <= pwdata[BIT_IRQEN];
                ctrl_q.blank   <= pwdata[BIT_BLANK];
            end
            if (paddr == OFS_CONFIG)
            begin
                cfg_q.clk_sel   <= pwdata[BIT_CLKSEL];
                cfg_q.half_bias <= pwdata[BIT_HALFB];
                cfg_q.duty      <= slfc_duty_e'(pwdata[POS_DUTY +: 2]);
                cfg_q.port_mask <= pwdata[POS_PMASK +: 3];
            end
            if (paddr == OFS_FRAME_RATE)
            begin
                pssel_q  <= pwdata[POS_PSSEL +: 3];
                clkdiv_q <= pwdata[POS_CLKDIV +: 3];
            end
            if (paddr == OFS_CONTRAST)
                contrast_q <= pwdata[3:0];
            for (int i = 0; i < NUM_COM; i++)
                if (paddr == OFS_DMEM_BASE + 8'(4 * i))
                    dmem_q[i] <= pwdata[NUM_SEG-1:0];
        end
    end

    // Frame flag; the hardware set wins over any clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (latch_ev)
            flag_q <= 1'b1;                                   // see RL5
        else if (irq_ack || (wr_ev && paddr == OFS_CTRL_STATUS && pwdata[BIT_IRQFLAG]))
            flag_q <= 1'b0;                                   // see RL7
    end

    // Interrupt request is a level, dropped with any of its three terms
    assign frame_irq = flag_q && ctrl_q.irq_en && global_irq_en;   // see RL6

    // Async source arrives as a sampled level; its rising edge is one tick
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            async_d1_q <= 1'b0;
        else
            async_d1_q <= ext_clock_select ? ext_clk_input : timer_osc_input;
    end
    assign lcd_tick = !cfg_q.clk_sel ||                             // see RL10
                      (!async_d1_q && (ext_clock_select ? ext_clk_input : timer_osc_input));

    // Tap of 16, 64 .. 4096 from the prescaler select
    always_comb
    begin
        unique case (pssel_q)                                     // see RL22
            3'd0:    tap_mask = 12'h00F;
            3'd1:    tap_mask = 12'h03F;
            3'd2:    tap_mask = 12'h07F;
            3'd3:    tap_mask = 12'h0FF;
            3'd4:    tap_mask = 12'h1FF;
            3'd5:    tap_mask = 12'h3FF;
            3'd6:    tap_mask = 12'h7FF;
            default: tap_mask = 12'hFFF;
        endcase
    end

    // Prescaler and divider; held at zero while off so a start is clean
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ps_q  <= '0;
            div_q <= 3'h0;
        end
        else if (!ctrl_q.enable)
        begin
            ps_q  <= '0;
            div_q <= 3'h0;
        end
        else if (lcd_tick)
        begin
            ps_q <= ps_q + 12'h001;
            if ((ps_q & tap_mask) == tap_mask)
                div_q <= (div_q >= clkdiv_q) ? 3'h0 : div_q + 3'h1;   // see RL22
        end
    end
    assign ps_tick = ctrl_q.enable && lcd_tick && ((ps_q & tap_mask) == tap_mask) &&
                     (div_q >= clkdiv_q);

    // Frame length: six ticks at third duty, eight otherwise
    assign k_last      = (cfg_q.duty == SLFC_DUTY_THIRD) ? K_THIRD : K_NORMAL;
    assign frame_start = ctrl_q.enable && (first_q || (ps_tick && phase_q == k_last));
    // Low-power waveform skips every second latch
    assign latch_ev    = frame_start && !(lp_lat_q && parity_q);   // see RL8

    // Frame sequencer; disabling stops it at once, mid-frame or not
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            phase_q  <= 3'h0;
            first_q  <= 1'b1;
            parity_q <= 1'b0;
            pol_q    <= 1'b0;
        end
        else if (!ctrl_q.enable)
        begin
            phase_q  <= 3'h0;                                     // see RL2
            first_q  <= 1'b1;
            parity_q <= 1'b0;
            pol_q    <= 1'b0;
        end
        else
        begin
            first_q <= 1'b0;
            if (frame_start)
            begin
                phase_q  <= 3'h0;                                 // see RL20
                parity_q <= latch_ev;
                pol_q    <= !pol_q;
            end
            else if (ps_tick)
                phase_q <= phase_q + 3'h1;
        end
    end

    // Working latches, loaded only at a frame start
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            blank_lat_q <= 1'b0;
            lp_lat_q    <= 1'b0;
            cc_lat_q    <= 4'h0;
            for (int i = 0; i < NUM_COM; i++)
                dlat_q[i] <= '0;
        end
        else if (latch_ev)
        begin
            blank_lat_q <= ctrl_q.blank;                          // see RL9
            lp_lat_q    <= ctrl_q.lp_wave;                        // see RL4
            cc_lat_q    <= contrast_q;                            // see RL1
            for (int i = 0; i < NUM_COM; i++)
                dlat_q[i] <= dmem_q[i];                           // see RL1
        end
    end

    // Common index: third and quarter use two ticks each, half four
    always_comb
    begin
        unique case (cfg_q.duty)                                  // see RL12
            SLFC_DUTY_STATIC: com_idx = 2'd0;
            SLFC_DUTY_HALF:   com_idx = {1'b0, phase_q[2]};
            default:          com_idx = phase_q[2:1];
        endcase
    end

    // Segment count from the port mask
    always_comb
    begin
        unique case (cfg_q.port_mask)                             // see RL13
            3'd0:    seg_cnt = 5'd13;
            3'd1:    seg_cnt = 5'd15;
            3'd2:    seg_cnt = 5'd17;
            3'd3:    seg_cnt = 5'd19;
            3'd4:    seg_cnt = 5'd21;
            3'd5:    seg_cnt = 5'd23;
            3'd6:    seg_cnt = 5'd24;
            default: seg_cnt = 5'd25;
        endcase
    end

    // Pin drive, registered; blanking grounds everything but keeps memory
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            seg_out       <= '0;
            com_out       <= '0;
            seg_lcd_sel   <= '0;
            com_lcd_sel   <= '0;
            pins_grounded <= 1'b0;
            bias_half     <= 1'b0;
            bias_static   <= 1'b0;
            lp_wave_out   <= 1'b0;
            contrast_out  <= 4'h0;
        end
        else
        begin
            for (int s = 0; s < NUM_SEG; s++)
            begin
                // Unmasked pins go back to the port when off
                seg_lcd_sel[s] <= ctrl_q.enable && (5'(s) < seg_cnt);   // see RL3
                // A set bit is driven against the common
                seg_out[s] <= ctrl_q.enable && !blank_lat_q &&
                              (dlat_q[com_idx][s] ? !pol_q : pol_q);   // see RL21
            end
            for (int c = 0; c < NUM_COM; c++)
            begin
                com_lcd_sel[c] <= ctrl_q.enable && (2'(c) <= cfg_q.duty);  // see RL12
                // Addressed common swings opposite to the idle ones
                com_out[c] <= ctrl_q.enable && !blank_lat_q &&
                              ((2'(c) == com_idx) ? pol_q : !pol_q);     // see RL20
            end
            pins_grounded <= ctrl_q.enable && blank_lat_q;          // see RL23
            bias_half     <= cfg_q.half_bias && (cfg_q.duty != SLFC_DUTY_STATIC);
            bias_static   <= (cfg_q.duty == SLFC_DUTY_STATIC);      // see RL11
            lp_wave_out   <= lp_lat_q;
            contrast_out  <= cc_lat_q;
        end
    end

    // Checks kept beside the logic they guard
    a_flag_on_latch: assert property (@(posedge clk_sys) disable iff (reset) // see RL5
        latch_ev |=> flag_q && !first_q)
        else $error("frame flag not set at latch");

    a_irq_terms: assert property (@(posedge clk_sys) disable iff (reset) // see RL6
        frame_irq |-> flag_q && ctrl_q.irq_en && global_irq_en)
        else $error("interrupt raised without all enables");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (reset) // see RL7
        (irq_ack && !latch_ev) |=> !flag_q)
        else $error("flag not cleared by vector");

    a_lp_every_second: assert property (@(posedge clk_sys) disable iff (reset) // see RL8
        (frame_start && lp_lat_q && parity_q) |-> !latch_ev)
        else $error("low power latched on consecutive frames");

    a_blank_ground: assert property (@(posedge clk_sys) disable iff (reset) // see RL9
        blank_lat_q |=> (seg_out == '0) && (com_out == '0))
        else $error("pins not grounded while blanked");

    a_stop_now: assert property (@(posedge clk_sys) disable iff (reset) // see RL2
        $fell(ctrl_q.enable) |=> phase_q == 3'h0 ##0 seg_lcd_sel == '0)
        else $error("controller did not stop at once");

    a_ports_off: assert property (@(posedge clk_sys) disable iff (reset) // see RL3
        !ctrl_q.enable ##1 !ctrl_q.enable |-> (com_lcd_sel == '0) && (seg_lcd_sel == '0))
        else $error("pins still owned while disabled");

    a_static_bias: assert property (@(posedge clk_sys) disable iff (reset) // see RL11
        (cfg_q.duty == SLFC_DUTY_STATIC) |=> bias_static && !bias_half)
        else $error("static duty without static bias");

    a_mask_min: assert property (@(posedge clk_sys) disable iff (reset) // see RL13
        (ctrl_q.enable && cfg_q.port_mask == 3'd0) |=> seg_lcd_sel == 25'h000_1FFF)
        else $error("port mask zero wrong pin set");

    a_com_zero_first: assert property (@(posedge clk_sys) disable iff (reset) // see RL20
        frame_start |=> com_idx == 2'd0)
        else $error("frame did not begin on common zero");

    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (reset) // see RL14
        (psel && !penable && !pwrite && paddr == OFS_CTRL_STATUS) |=>
            (rdata_q[5] == 1'b0) && (rdata_q[2:1] == 2'b00) && (rdata_q[31:8] == '0))
        else $error("reserved bits read non-zero");
endmodule : slfc_frame_ctrl

// *** sim/slfc_panel.sv ***
`timescale 1ns/1ps
module slfc_panel (
    input  wire logic [24:0] seg_out,     // Segment levels
    input  wire logic [24:0] seg_lcd_sel, // Segment pins owned by driver
    input  wire logic [3:0]  com_out,     // Common levels
    input  wire logic [3:0]  com_lcd_sel, // Common pins owned by driver
    output logic      [24:0] lit_com0     // Segments darkened on common 0
);
    // A passive cell darkens only across opposite phase; a pin given back
    // to the port cannot drive the glass, so it never counts as lit
    assign lit_com0 = seg_lcd_sel & (seg_out ^ {25{com_out[0]}})
                      & {25{com_lcd_sel[0]}};
endmodule : slfc_panel

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
    import slfc_pkg::*;
    logic              clk_sys = 1'b0; // 125 MHz
    logic              reset   = 1'b1; // Held six cycles
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [APB_AW-1:0] paddr   = '0;
    logic [31:0]       pwdata  = '0;
    logic              osc     = 1'b0; // Oscillator level, six clocks a period
    logic              gie     = 1'b0; // CPU global enable
    logic              irq_ack = 1'b0; // Vector taken
    logic              pready, pslverr, frame_irq, pins_grounded, er;
    logic              bias_half, bias_static, lp_wave_out;
    logic [31:0]       prdata, rd;
    logic [24:0]       seg_out, seg_lcd_sel, lit;
    logic [3:0]        com_out, com_lcd_sel, contrast_out;
    int                n_errors  = 0;
    int                tests_run = 0;
    int                segn[8]   = '{13, 15, 17, 19, 21, 23, 24, 25}; // Pins per mask code
    longint            cyc       = 0; // Free cycle count
    longint            t_irq     = 0; // Cycle of last frame request
    longint            gap;

    // Clocks and cycle count
    always #4 clk_sys = ~clk_sys;
    always #24 osc = ~osc;
    always @(posedge clk_sys) cyc <= cyc + 1;

    slfc_frame_ctrl u_dut (
        .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .timer_osc_input(osc), .ext_clk_input(1'b0), .ext_clock_select(1'b0),
        .global_irq_en(gie), .irq_ack, .frame_irq, .seg_out, .seg_lcd_sel, .com_out,
        .com_lcd_sel, .pins_grounded, .bias_half, .bias_static, .lp_wave_out, .contrast_out
    );
    slfc_panel u_panel (.seg_out, .seg_lcd_sel, .com_out, .com_lcd_sel, .lit_com0(lit));

    // Count a comparison, report a mismatch at once
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk(what, exp, rd);
    endtask : rdc

    // Wait for the frame request, note its spacing, then take the vector
    task automatic frame();
        do
        begin
            @(negedge clk_sys);
        end
        while (frame_irq !== 1'b1);
        gap = cyc - t_irq;
        t_irq = cyc;
        @(posedge clk_sys);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
    endtask : frame

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Whole run is about 3100 cycles; this is 50000 cycles, some sixteen times that
    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdc("ctrl reset", OFS_CTRL_STATUS, 32'h0000_0000);
        rdc("rate reset", OFS_FRAME_RATE, 32'h0000_0000);
        wr(OFS_CONFIG, 32'h0000_00FF);
        rdc("cfg reserved", OFS_CONFIG, 32'h0000_00F7);
        wr(OFS_CTRL_STATUS, 32'h0000_006F);
        rdc("ctrl reserved", OFS_CTRL_STATUS, 32'h0000_0049);
        wr(OFS_CTRL_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000, rd, er);
        chk("unmapped", 32'h0000_0001, {31'h0, er});
        // Each mask code and duty code, set up while the driver is off
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_CONFIG, {24'h00_0000, 2'h1, i[1:0], 1'b0, i[2:0]});
            wr(OFS_CTRL_STATUS, 32'h0000_0080);
            repeat (3) @(negedge clk_sys);
            chk("seg pins", (32'h1 << segn[i]) - 32'h1, {7'h0, seg_lcd_sel});
            chk("com pins", (32'h1 << (i % 4 + 1)) - 32'h1, {28'h0, com_lcd_sel});
            chk("bias", {30'h0, i[1:0] == 2'h0, i[1:0] != 2'h0}, {30'h0, bias_static, bias_half});
            wr(OFS_CTRL_STATUS, 32'h0000_0000);
            repeat (2) @(negedge clk_sys);
            chk("released", 32'h0000_0000, {3'h0, seg_lcd_sel, com_lcd_sel});
        end
        // Static duty, all segments; fastest frame of 128 cycles
        wr(OFS_CONFIG, 32'h0000_0007);
        wr(OFS_DMEM_BASE, 32'h0155_5555);
        wr(OFS_CONTRAST, 32'h0000_0009);
        gie <= 1'b1;
        wr(OFS_CTRL_STATUS, 32'h0000_0088);
        frame();
        @(negedge clk_sys);
        chk("ack clears", 32'h0000_0000, {31'h0, frame_irq});
        chk("lit", 32'h0155_5555, {7'h0, lit});
        chk("contrast", 32'h0000_0009, {28'h0, contrast_out});
        // Mid-frame updates wait for the next frame start
        wr(OFS_DMEM_BASE, 32'h00AA_AAAA);
        wr(OFS_CONTRAST, 32'h0000_0003);
        wr(OFS_CTRL_STATUS, 32'h0000_0089);
        @(negedge clk_sys);
        chk("lit held", 32'h0155_5555, {7'h0, lit});
        chk("not blanked", 32'h0000_0000, {31'h0, pins_grounded});
        frame();
        chk("frame gap", 32'h0000_0080, 32'(gap));
        @(negedge clk_sys);
        chk("blanked", 32'h2000_0000, {2'h0, pins_grounded, seg_out, com_out});
        chk("contrast new", 32'h0000_0003, {28'h0, contrast_out});
        rdc("memory kept", OFS_DMEM_BASE, 32'h00AA_AAAA);
        wr(OFS_CTRL_STATUS, 32'h0000_0088);
        frame();
        @(negedge clk_sys);
        chk("lit new", 32'h00AA_AAAA, {7'h0, lit});
        // Global enable masks the request, not the flag
        @(posedge clk_sys);
        gie <= 1'b0;
        repeat (130) @(negedge clk_sys);
        chk("irq masked", 32'h0000_0000, {31'h0, frame_irq});
        wr(OFS_CTRL_STATUS, 32'h0000_0088);
        rdc("flag kept", OFS_CTRL_STATUS, 32'h0000_0098);
        gie <= 1'b1;
        @(negedge clk_sys);
        chk("irq raised", 32'h0000_0001, {31'h0, frame_irq});
        wr(OFS_CTRL_STATUS, 32'h0000_0098);
        rdc("flag cleared", OFS_CTRL_STATUS, 32'h0000_0088);
        // Low-power waveform: latch and flag every second frame
        frame();
        wr(OFS_CTRL_STATUS, 32'h0000_00C8);
        @(negedge clk_sys);
        chk("wave held", 32'h0000_0000, {31'h0, lp_wave_out});
        frame();
        frame();
        frame();
        chk("lp gap", 32'h0000_0100, 32'(gap));
        chk("wave low power", 32'h0000_0001, {31'h0, lp_wave_out});
        // Orderly shutdown: blank with the flag cleared, let it take hold, then stop
        wr(OFS_CTRL_STATUS, 32'h0000_00D9);
        frame();
        @(negedge clk_sys);
        chk("blank before off", 32'h0000_0001, {31'h0, pins_grounded});
        wr(OFS_CTRL_STATUS, 32'h0000_0000);
        repeat (2) @(negedge clk_sys);
        chk("stopped", 32'h0000_0000, {3'h0, seg_lcd_sel, com_lcd_sel});
        // Oscillator source: one tick per oscillator period of six clocks
        wr(OFS_CONFIG, 32'h0000_0087);
        wr(OFS_CTRL_STATUS, 32'h0000_0088);
        frame();
        frame();
        frame();
        chk("osc gap", 32'h0000_0300, 32'(gap));
        stop_test();
    end
endmodule : tb
